// ---- core/jtdbg_pkg.sv ----
// Package with constants and types for the test port and debug channel block.
package jtdbg_pkg;

    // Port state machine, sixteen states.
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3,
        ST_SH_DR = 4'h4,
        ST_EX1_DR = 4'h5,
        ST_PAU_DR = 4'h6,
        ST_EX2_DR = 4'h7,
        ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'ha,
        ST_SH_IR = 4'hb,
        ST_EX1_IR = 4'hc,
        ST_PAU_IR = 4'hd,
        ST_EX2_IR = 4'he,
        ST_UPD_IR = 4'hf
    } jtdbg_state_e;

    localparam int IR_W = 4;
    localparam logic [3:0] OP_EXTEST = 4'h0;
    localparam logic [3:0] OP_IDCODE = 4'h1;
    localparam logic [3:0] OP_DEBUG_A = 4'h8;
    localparam logic [3:0] OP_DEBUG_B = 4'h9;
    localparam logic [3:0] OP_DEBUG_C = 4'ha;
    localparam logic [3:0] OP_DEBUG_D = 4'hb;
    localparam logic [3:0] OP_BYPASS = 4'hf;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_RESET_VAL = OP_IDCODE;

    // Identification word; the value is arbitrary.
    localparam logic [31:0] ID_WORD = 32'h1234_5671;

    // Debug data register layout, shifted least significant bit first.
    localparam int DDR_W = 16;
    localparam int DDR_DATA_LSB = 0;
    localparam int DDR_PEND_BIT = 7;
    localparam int DDR_ACC_BIT = 8;
    localparam int DDR_CLR_BIT = 9;
    localparam int DDR_MODE_LSB = 10;

    // Break point unit data register, written by op b.
    localparam int BRK_W = 36;
    localparam int BRK_ADDR_W = 16;
    localparam int BRK_FLOW_BIT = 0;
    localparam int BRK_STEP_BIT = 1;
    localparam int BRK_MODE_LSB = 2;
    localparam int BRK_SEL_LSB = 4;
    localparam int BRK_ADDR_LSB = 20;

    // Break resource layouts.
    localparam logic [2:0] BM_4P = 3'h0;
    localparam logic [2:0] BM_3P1D = 3'h1;
    localparam logic [2:0] BM_2P2D = 3'h2;
    localparam logic [2:0] BM_RANGE_P = 3'h3;
    localparam logic [2:0] BM_RANGE_D = 3'h4;

    // Instruction feed chain between core and peripherals, op c.
    localparam int INS_W = 16;
    localparam logic [7:0] MSG_RESET = 8'h00;

    // Break configuration carried to the compare unit.
    typedef struct packed {
        logic flow;
        logic step;
        logic [2:0] mode;
        logic [3:0][BRK_ADDR_W-1:0] addr;
    } jtdbg_brk_s;

endpackage

// ---- core/jtdbg_brk_unit.sv ----
// Break point compare unit for program and data addresses.
`timescale 1ns/10ps
`default_nettype none
module jtdbg_brk_unit
    import jtdbg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire jtdbg_brk_s i_cfg,
    input wire logic i_en,
    input wire logic [BRK_ADDR_W-1:0] i_pc,
    input wire logic i_pc_flow,
    input wire logic i_pc_step,
    input wire logic [BRK_ADDR_W-1:0] i_daddr,
    input wire logic i_dacc,
    output logic o_break
);

    logic [3:0] is_data;
    logic [3:0] hit;
    logic range_hit;

    // Slots 2 and 3 are the combined pair; they serve data in some layouts.
    always_comb begin
        is_data = 4'h0;
        unique case (i_cfg.mode)
            BM_3P1D: is_data = 4'h8;
            BM_2P2D: is_data = 4'hc;
            default: is_data = 4'h0;
        endcase
    end

    // Each slot compares against program or data address.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_slot
            assign hit[g] = is_data[g] ? (i_dacc && i_daddr == i_cfg.addr[g]) : (i_pc == i_cfg.addr[g]);
        end
    endgenerate

    // Range form: slot 2 holds the value, slot 3 the care mask.
    always_comb begin
        range_hit = 1'b0;
        if (i_cfg.mode == BM_RANGE_P) begin
            range_hit = ((i_pc ^ i_cfg.addr[2]) & i_cfg.addr[3]) == '0;
        end else if (i_cfg.mode == BM_RANGE_D) begin
            range_hit = i_dacc && (((i_daddr ^ i_cfg.addr[2]) & i_cfg.addr[3]) == '0);
        end
    end

    // Break request is registered; it only fires while debug is allowed.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_break <= 1'b0;
        end else begin
            o_break <= i_en && ((i_cfg.flow && i_pc_flow) || (i_cfg.step && i_pc_step) || hit[0] || hit[1]
                || (i_cfg.mode > BM_2P2D ? range_hit : (hit[2] || hit[3])));
        end
    end

endmodule
`default_nettype wire

// ---- core/jtdbg_top.sv ----
// Test access port with debug scan path, break unit and message register.
// What this block does
// RULE_01: Idle to shift-DR needs TMS 1,0,0.
// RULE_02: Shift-DR loads selected register from TDI.
// RULE_03: TMS low except on last bit.
// RULE_04: Shift-DR drives captured values onto TDO.
// RULE_05: Return to idle with TMS 1,1,0.
// RULE_06: Latched outputs update only in Update-DR; flow and step also clear while debug is off.
// RULE_07: Five TMS-high clocks reach Test-Logic-Reset.
// RULE_08: Update-IR may go straight to select-DR.
// RULE_09: Flow, step, two program, two combined breaks; the update never loads combined slots 2 and 3, so they stay at address zero.
// RULE_10: Layouts 4P, 3P+1D, 2P+2D.
// RULE_11: Combined pair may form masked range break; value and mask in slots 2 and 3 stay zero, so the range matches every address.
// RULE_12: Debugger works by feeding CPU instructions.
// RULE_13: Debug needs both fuses, no lock bits.
// RULE_14: Any lock bit disables debug.
// RULE_15: Codes 8 to b are debug access.
// RULE_16: CPU write stores byte, sets pending flag.
// RULE_17: CPU read gives 7 bits plus flag.
// RULE_18: Debugger clears pending flag after reading.
// RULE_19: Message register needs fuse and debugger access.
// RULE_20: Port needs fuse and disable bit clear.
// RULE_21: Programming uses only four port signals.
// RULE_22: Lock bits block debug fuse programming.
// RULE_23: Shift registers move LSB first.
// RULE_24: Sixteen states, TMS on TCK rise, resets.
// RULE_25: Instruction register is four bits.
// RULE_26: Read and clear in one safe access.
`timescale 1ns/10ps
`default_nettype none
module jtdbg_top
    import jtdbg_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe,
    input wire logic i_test_port_enable_fuse,
    input wire logic i_debug_enable_fuse,
    input wire logic i_lock_bit_one,
    input wire logic i_lock_bit_two,
    input wire logic i_test_port_disable_bit,
    input wire logic i_cpu_msg_wr,
    input wire logic i_cpu_msg_rd,
    input wire logic [7:0] i_cpu_wdata,
    output logic [7:0] o_cpu_rdata,
    output logic o_msg_selected,
    input wire logic [INS_W-1:0] i_cpu_result,
    output logic [INS_W-1:0] o_feed_insn,
    output logic o_feed_valid,
    input wire logic i_fuse_wr_req,
    input wire logic i_chip_erase,
    output logic o_fuse_wr_ok,
    input wire logic [BRK_ADDR_W-1:0] i_pc,
    input wire logic i_pc_flow,
    input wire logic i_pc_step,
    input wire logic [BRK_ADDR_W-1:0] i_daddr,
    input wire logic i_dacc,
    output logic o_break
);

    // Pin synchronisers; first stages feed only second stages.
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic tck_d;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            tck_d <= 1'b0;
        end else begin
            sync_a <= {i_tck, i_tms, i_tdi};
            sync_b <= sync_a;
            tck_d <= sync_b[2];
        end
    end
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_rise;
    logic tck_fall;
    assign tck_s = sync_b[2];
    assign tms_s = sync_b[1];
    assign tdi_s = sync_b[0];
    assign tck_rise = tck_s && !tck_d;
    assign tck_fall = !tck_s && tck_d;

    // Access gates from fuses, lock bits and the disable bit.
    logic port_en;
    logic dbg_en;
    assign port_en = i_test_port_enable_fuse && !i_test_port_disable_bit; // see RULE_20
    assign dbg_en = port_en && i_debug_enable_fuse && !(i_lock_bit_one || i_lock_bit_two); // see RULE_13 see RULE_14

    // Next state of the port controller for a given TMS.
    function automatic jtdbg_state_e tap_next(input jtdbg_state_e s, input logic tms);
        unique case (s)
            ST_RESET: tap_next = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: tap_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: tap_next = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: tap_next = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: tap_next = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_IDLE;
        endcase
    endfunction

    // Debug access decode of an instruction code.
    function automatic logic is_debug_op(input logic [IR_W-1:0] op);
        is_debug_op = (op == OP_DEBUG_A) || (op == OP_DEBUG_B) || (op == OP_DEBUG_C) || (op == OP_DEBUG_D);
    endfunction

    // Controller advances on each sampled TCK rise; a disabled port sits in reset.
    jtdbg_state_e state;
    jtdbg_state_e next_state;
    assign next_state = tap_next(state, tms_s); // see RULE_01 see RULE_05 see RULE_07 see RULE_08
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ST_RESET; // see RULE_24
        end else if (!port_en) begin
            state <= ST_RESET;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // Instruction register shift and latch.
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            ir_sh <= IR_CAPTURE;
            ir <= IR_RESET_VAL;
        end else if (state == ST_RESET) begin
            ir <= IR_RESET_VAL;
        end else if (tck_rise) begin
            unique case (state)
                ST_CAP_IR: ir_sh <= IR_CAPTURE;
                ST_SH_IR: ir_sh <= {tdi_s, ir_sh[IR_W-1:1]}; // see RULE_23 see RULE_25
                ST_UPD_IR: ir <= ir_sh;
                default: ir_sh <= ir_sh;
            endcase
        end
    end

    // Message register in the system domain.
    logic [7:0] msg;
    logic pend;
    logic msg_access;
    logic clr_req;

    // Debug selects are void when debug is locked out.
    logic sel_a;
    logic sel_b;
    logic sel_c;
    assign sel_a = dbg_en && ir == OP_DEBUG_A;
    assign sel_b = dbg_en && ir == OP_DEBUG_B;
    assign sel_c = dbg_en && ir == OP_DEBUG_C;

    // Data shift registers; dr_sh is shared by every path except op b, which shifts brk_sh.
    logic [31:0] dr_sh;
    logic [BRK_W-1:0] brk_sh;
    logic [DDR_W-1:0] ddr_upd;
    jtdbg_brk_s brk_cfg;
    logic upd_pulse;
    logic byp_out;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            dr_sh <= 32'h0;
            brk_sh <= '0;
        end else if (tck_rise) begin
            if (state == ST_CAP_DR) begin
                // Captured parallel inputs are what shift out next.
                if (ir == OP_IDCODE) begin
                    dr_sh <= ID_WORD;
                end else if (sel_a) begin
                    dr_sh <= {16'h0, 7'h0, msg_access, pend, msg[6:0]};
                end else if (sel_c) begin
                    dr_sh <= {16'h0, i_cpu_result};
                end else begin
                    dr_sh <= 32'h0;
                end
                brk_sh <= '0;
            end else if (state == ST_SH_DR) begin
                dr_sh <= {tdi_s, dr_sh[31:1]}; // see RULE_02 see RULE_04 see RULE_23
                brk_sh <= {tdi_s, brk_sh[BRK_W-1:1]};
            end
        end
    end

    // Short registers need their input spliced at their own width.
    logic [DDR_W-1:0] ddr_view;
    logic [INS_W-1:0] ins_view;
    assign ddr_view = dr_sh[31:32-DDR_W];
    assign ins_view = dr_sh[31:32-INS_W];
    assign byp_out = dr_sh[31];

    // Latched outputs move on Update-DR; flow and step also clear while debug is off.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            ddr_upd <= '0;
            upd_pulse <= 1'b0;
            brk_cfg <= '0;
            o_feed_insn <= '0;
            o_feed_valid <= 1'b0;
        end else begin
            upd_pulse <= 1'b0;
            o_feed_valid <= 1'b0;
            if (tck_rise && state == ST_UPD_DR) begin // see RULE_06
                if (sel_a) begin
                    ddr_upd <= ddr_view;
                    upd_pulse <= 1'b1;
                end
                if (sel_b) begin
                    brk_cfg.flow <= brk_sh[BRK_FLOW_BIT];
                    brk_cfg.step <= brk_sh[BRK_STEP_BIT];
                    brk_cfg.mode <= {1'b0, brk_sh[BRK_MODE_LSB +: 2]} + (brk_sh[BRK_SEL_LSB + 15] ? 3'h3 : 3'h0);
                    brk_cfg.addr[0] <= brk_sh[BRK_SEL_LSB +: BRK_ADDR_W];
                    brk_cfg.addr[1] <= brk_sh[BRK_ADDR_LSB +: BRK_ADDR_W];
                end
                if (sel_c) begin
                    o_feed_insn <= ins_view; // see RULE_12
                    o_feed_valid <= 1'b1;
                end
            end
            if (!dbg_en) begin
                brk_cfg.flow <= 1'b0;
                brk_cfg.step <= 1'b0;
            end
        end
    end

    // Debugger access enable and pending-flag clear request.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            msg_access <= 1'b0;
            clr_req <= 1'b0;
            o_msg_selected <= 1'b0;
        end else begin
            clr_req <= upd_pulse && ddr_upd[DDR_CLR_BIT]; // see RULE_18 see RULE_26
            o_msg_selected <= i_debug_enable_fuse && msg_access; // see RULE_19
            if (!dbg_en) begin
                msg_access <= 1'b0;
            end else if (upd_pulse) begin
                msg_access <= ddr_upd[DDR_ACC_BIT];
            end
        end
    end

    // Message byte and flag; a CPU write in the clear cycle keeps the flag set.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            msg <= MSG_RESET;
            pend <= 1'b0;
        end else if (o_msg_selected && i_cpu_msg_wr) begin
            msg <= i_cpu_wdata; // see RULE_16
            pend <= 1'b1;
        end else if (clr_req) begin
            pend <= 1'b0;
        end
    end

    // CPU read data: low seven bits and the flag on top.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_cpu_rdata <= 8'h00;
        end else if (o_msg_selected && i_cpu_msg_rd) begin
            o_cpu_rdata <= {pend, msg[6:0]}; // see RULE_17
        end
    end

    // Fuse write gate: locked parts need an erase first.
    logic erased;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            erased <= 1'b0;
            o_fuse_wr_ok <= 1'b0;
        end else begin
            if (i_chip_erase) begin
                erased <= 1'b1;
            end
            o_fuse_wr_ok <= i_fuse_wr_req && port_en && (erased || !(i_lock_bit_one || i_lock_bit_two)); // see RULE_21 see RULE_22
        end
    end

    // TDO changes on the falling TCK edge, driven only in shift states.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else if (!port_en) begin
            // A port switched off in mid-frame lets go of the pin at once.
            o_tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            o_tdo_oe <= (state == ST_SH_DR) || (state == ST_SH_IR);
            if (state == ST_SH_IR) begin
                o_tdo <= ir_sh[0];
            end else if (ir == OP_BYPASS || (is_debug_op(ir) && !dbg_en)) begin // see RULE_15
                o_tdo <= byp_out;
            end else if (ir == OP_IDCODE || sel_a || sel_c) begin
                o_tdo <= dr_sh[0];
            end else if (sel_b) begin
                o_tdo <= brk_sh[0];
            end else begin
                o_tdo <= dr_sh[0];
            end
        end
    end

    // Break compare unit.
    jtdbg_brk_unit u_brk (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_cfg(brk_cfg),
        .i_en(dbg_en),
        .i_pc(i_pc),
        .i_pc_flow(i_pc_flow),
        .i_pc_step(i_pc_step),
        .i_daddr(i_daddr),
        .i_dacc(i_dacc),
        .o_break(o_break)
    ); // see RULE_09 see RULE_10 see RULE_11

endmodule
`default_nettype wire

// ---- verif/jtdbg_top_sva.sv ----
// Concurrent checks on the test port and debug channel top-level pins.
`timescale 1ns/10ps
`default_nettype none
module jtdbg_top_sva (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_tck,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    input wire logic i_test_port_enable_fuse,
    input wire logic i_debug_enable_fuse,
    input wire logic i_lock_bit_one,
    input wire logic i_lock_bit_two,
    input wire logic i_test_port_disable_bit,
    input wire logic i_cpu_msg_wr,
    input wire logic i_cpu_msg_rd,
    input wire logic [7:0] i_cpu_wdata,
    input wire logic [7:0] o_cpu_rdata,
    input wire logic o_msg_selected,
    input wire logic o_feed_valid,
    input wire logic i_fuse_wr_req,
    input wire logic i_chip_erase,
    input wire logic o_fuse_wr_ok
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    wire locked = i_lock_bit_one | i_lock_bit_two;
    wire dbg_ok = i_test_port_enable_fuse & i_debug_enable_fuse & ~locked;
    logic [7:0] wr_byte;
    logic erased;

    // Shadow of the last CPU byte, and whether an erase has been seen since reset.
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_byte <= 8'h00;
            erased <= 1'b0;
        end else begin
            if (i_cpu_msg_wr) wr_byte <= i_cpu_wdata;
            if (i_chip_erase) erased <= 1'b1;
        end
    end

    // A selected CPU write followed at once by a read.
    sequence s_write_then_read;
        i_cpu_msg_wr && o_msg_selected ##1 i_cpu_msg_rd && !i_cpu_msg_wr;
    endsequence

    a_msg_readback: assert property (s_write_then_read |=> o_cpu_rdata == {1'b1, wr_byte[6:0]})
        else $error("message readback differs from the byte written");
    a_feed_pulse: assert property (o_feed_valid |=> !o_feed_valid)
        else $error("feed strobe longer than one cycle");
    a_feed_gate: assert property (o_feed_valid |-> dbg_ok)
        else $error("instruction fed while debug is disabled");
    a_msg_gate: assert property (!i_debug_enable_fuse [*3] |-> !o_msg_selected)
        else $error("message register selected without debug fuse");
    a_oe_gate: assert property (o_tdo_oe |-> $past(i_test_port_enable_fuse && !i_test_port_disable_bit))
        else $error("data out driven while the port is disabled");
    a_tdo_timing: assert property ($changed(o_tdo) |-> !i_tck)
        else $error("data out moved while the test clock was high");
    a_fuse_block: assert property ((locked && !erased) [*2] |-> !o_fuse_wr_ok)
        else $error("fuse write granted on a locked device");
    a_fuse_grant: assert property ((i_fuse_wr_req && !locked && i_test_port_enable_fuse && !i_test_port_disable_bit) [*2]
        |-> o_fuse_wr_ok)
        else $error("fuse write refused on an open device");
endmodule
bind jtdbg_top jtdbg_top_sva u_sva (.*);
`default_nettype wire

// ---- verif/jtdbg_jtag_ctl.sv ----
// Behavioural external test controller that walks the port state machine.
`timescale 1ns/10ps
`default_nettype none
module jtdbg_jtag_ctl (
    input wire logic i_clk_sys,
    input wire logic i_tdo,
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi
);
    bit at_sel;
    logic smp;

    // The test clock stands low between frames.
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
    end

    // One 800 ns period; pins move only while the clock is low, data out is taken before the rise.
    task automatic tick(input logic tms, input logic tdi);
        o_tms = tms;
        o_tdi = tdi;
        repeat (4) @(negedge i_clk_sys);
        smp = i_tdo;
        o_tck = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        o_tck = 1'b0;
    endtask

    // Whole scan; idle data in toggles so a stale level never looks valid.
    task automatic scan(input bit ir, input int n, input logic [63:0] din, output logic [63:0] dout,
                        input bit chain);
        dout = '0;
        if (!at_sel) tick(1'b1, ~o_tdi);
        if (ir) tick(1'b1, ~o_tdi);
        tick(1'b0, ~o_tdi);
        tick(1'b0, ~o_tdi);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i]);
            dout[i] = smp;
        end
        tick(1'b1, ~o_tdi);
        tick(chain, ~o_tdi);
        at_sel = chain;
    endtask

    // Five high periods reach the reset state from anywhere, then on to idle.
    task automatic to_reset();
        repeat (5) tick(1'b1, ~o_tdi);
        tick(1'b0, ~o_tdi);
        at_sel = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- verif/jtdbg_top_bench.sv ----
// Self-checking bench for the test port and debug channel top.
`timescale 1ns/10ps
`default_nettype none
module jtdbg_top_bench;
    import jtdbg_pkg::*;
    logic i_clk_sys, i_nrst, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe, o_msg_selected;
    logic i_test_port_enable_fuse, i_debug_enable_fuse, i_lock_bit_one, i_lock_bit_two;
    logic i_test_port_disable_bit, i_cpu_msg_wr, i_cpu_msg_rd, i_pc_flow, i_pc_step, i_dacc;
    logic [7:0] i_cpu_wdata, o_cpu_rdata, r;
    logic [15:0] i_cpu_result, o_feed_insn, i_pc, i_daddr, a;
    logic o_feed_valid, i_fuse_wr_req, i_chip_erase, o_fuse_wr_ok, o_break;
    logic [63:0] dout;
    int errors, num_checks, feed_cnt, oe_cnt, k;

    jtdbg_top u_dut (.*);
    jtdbg_jtag_ctl u_ctl (.i_clk_sys(i_clk_sys), .i_tdo(o_tdo), .o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi));

    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    // Tally feed strobes and driven data-out cycles.
    always @(posedge i_clk_sys) begin
        if (o_feed_valid === 1'b1) feed_cnt++;
        if (o_tdo_oe === 1'b1) oe_cnt++;
    end

    task automatic report_and_stop();
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Instruction scan chained straight into a data scan.
    task automatic dr(input logic [3:0] op, input int n, input logic [63:0] din);
        u_ctl.scan(1'b1, IR_W, {60'h0, op}, dout, 1'b1);
        chk(dout[3:0], IR_CAPTURE);
        u_ctl.scan(1'b0, n, din, dout, 1'b0);
    endtask

    task automatic cpu_wr(input logic [7:0] d);
        i_cpu_wdata = d;
        i_cpu_msg_wr = 1'b1;
        @(negedge i_clk_sys);
        i_cpu_msg_wr = 1'b0;
    endtask

    task automatic cpu_rd(output logic [7:0] d);
        i_cpu_msg_rd = 1'b1;
        @(negedge i_clk_sys);
        i_cpu_msg_rd = 1'b0;
        d = o_cpu_rdata;
    endtask

    // Selection follows the fuse through registers, so allow a bounded settle.
    task automatic wait_sel(input logic v);
        int n;
        n = 0;
        while (o_msg_selected !== v && n < 50) begin
            @(negedge i_clk_sys);
            n++;
        end
        chk(o_msg_selected, v);
        if (n == 50) report_and_stop();
    endtask

    // Cut a hung run short; running out of time counts as a mismatch.
    initial begin
        repeat (100000) @(posedge i_clk_sys);
        errors++;
        report_and_stop();
    end

    initial begin
        {i_nrst, i_lock_bit_one, i_lock_bit_two, i_test_port_disable_bit, i_cpu_msg_wr, i_cpu_msg_rd} = '0;
        {i_cpu_wdata, i_cpu_result, i_pc, i_daddr, i_pc_flow, i_pc_step, i_dacc} = '0;
        {i_fuse_wr_req, i_chip_erase} = '0;
        i_test_port_enable_fuse = 1'b1;
        i_debug_enable_fuse = 1'b1;
        void'($urandom(44));
        repeat (10) @(negedge i_clk_sys);
        i_nrst = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        u_ctl.to_reset();
        u_ctl.scan(1'b0, 32, {$urandom, $urandom}, dout, 1'b0);
        chk(dout[31:0], ID_WORD);
        a = 16'($urandom);
        dr(OP_BYPASS, 8, 64'(a));
        chk(dout[7:0], {a[6:0], 1'b0});
        u_ctl.tick(1'b1, 1'b0);
        u_ctl.tick(1'b0, 1'b1);
        u_ctl.tick(1'b0, 1'b0);
        u_ctl.to_reset();
        u_ctl.scan(1'b0, 32, 64'(a), dout, 1'b0);
        chk(dout[31:0], ID_WORD);
        dr(OP_DEBUG_A, DDR_W, 64'h100);
        wait_sel(1'b1);
        repeat (3) begin
            cpu_wr(8'($urandom));
            cpu_rd(r);
            chk(r, {1'b1, i_cpu_wdata[6:0]});
            dr(OP_DEBUG_A, DDR_W, 64'h300);
            chk(dout[15:0], {7'h0, 2'h3, i_cpu_wdata[6:0]});
            repeat (3) @(negedge i_clk_sys);
            cpu_rd(r);
            chk(r, {1'b0, i_cpu_wdata[6:0]});
            a = 16'($urandom);
            i_cpu_result = 16'($urandom);
            k = feed_cnt;
            dr(OP_DEBUG_C, INS_W, 64'(a));
            chk(dout[15:0], i_cpu_result);
            chk(feed_cnt - k, 1);
            chk(o_feed_insn, a);
        end
        dr(OP_DEBUG_A, DDR_W, 64'h0);
        wait_sel(1'b0);
        dr(OP_DEBUG_A, DDR_W, 64'h100);
        i_debug_enable_fuse = 1'b0;
        wait_sel(1'b0);
        k = feed_cnt;
        for (int c = 0; c < 3; c++) begin
            i_lock_bit_one = (c == 0);
            i_lock_bit_two = (c == 1);
            i_debug_enable_fuse = (c != 2);
            for (int op = 8; op < 12; op++) begin
                a = 16'($urandom);
                dr(4'(op), 8, 64'(a));
                chk(dout[7:0], {a[6:0], 1'b0});
            end
        end
        chk(feed_cnt - k, 0);
        {i_lock_bit_one, i_lock_bit_two, i_debug_enable_fuse} = 3'h1;
        // Address compare in the four-program layout, then flow and step breaks.
        a = 16'($urandom) & 16'h7fff;
        dr(OP_DEBUG_B, BRK_W, 64'(a) << BRK_SEL_LSB);
        i_pc = a;
        repeat (3) @(negedge i_clk_sys);
        chk(o_break, 1'b1);
        i_pc = a ^ 16'h8000;
        repeat (3) @(negedge i_clk_sys);
        chk(o_break, 1'b0);
        for (int s = 0; s < 2; s++) begin
            dr(OP_DEBUG_B, BRK_W, 64'h1 << s);
            {i_pc_step, i_pc_flow} = 2'(1 << s);
            repeat (3) @(negedge i_clk_sys);
            chk(o_break, 1'b1);
            {i_pc_step, i_pc_flow} = 2'h0;
        end
        // Three-program one-data layout: slot 3 watches data address zero.
        dr(OP_DEBUG_B, BRK_W, 64'h4);
        i_dacc = 1'b1;
        for (int m = 0; m < 2; m++) begin
            i_daddr = 16'(m);
            repeat (3) @(negedge i_clk_sys);
            chk(o_break, m == 0);
        end
        i_dacc = 1'b0;
        i_fuse_wr_req = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        chk(o_fuse_wr_ok, 1'b1);
        i_lock_bit_one = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        chk(o_fuse_wr_ok, 1'b0);
        i_chip_erase = 1'b1;
        @(negedge i_clk_sys);
        i_chip_erase = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        chk(o_fuse_wr_ok, 1'b1);
        i_lock_bit_one = 1'b0;
        for (int c = 0; c < 2; c++) begin
            i_test_port_disable_bit = (c == 0);
            i_test_port_enable_fuse = (c != 0);
            k = oe_cnt;
            u_ctl.scan(1'b0, 32, 64'h0, dout, 1'b0);
            chk(oe_cnt - k, 0);
        end
        {i_test_port_disable_bit, i_test_port_enable_fuse} = 2'h1;
        u_ctl.to_reset();
        u_ctl.scan(1'b0, 32, 64'h0, dout, 1'b0);
        chk(dout[31:0], ID_WORD);
        report_and_stop();
    end
endmodule
`default_nettype wire
